// ==== rtl/opm_defines.vh ====
// Constants for the programming mode entry and slave programming port
`ifndef OPM_DEFINES_VH
`define OPM_DEFINES_VH
`define OPM_MODE_SERIAL 4'h0
`define OPM_MODE_SLAVE 4'h5
`define OPM_MODE_DUMP 4'h6
`define OPM_MODE_AUTO 4'hc
`define OPM_CMD_BIT 0
`define OPM_ADDR_W 15
`define OPM_DATA_W 16
`define OPM_MEM_DEPTH 16
`define OPM_MEM_AW 4
`define OPM_AUTO_WORDS 16'h0010
`define OPM_MEM_RESET 16'hffff
`endif

// ==== rtl/opm_port.v ====
// Programming mode entry, slave handshake and auto/dump bus sequencer
`timescale 1ns/1ps
`default_nettype none
`include "opm_defines.vh"

module opm_port (
	input wire core_clk, // 25 MHz clock
	input wire reset, // Synchronous reset, active high
	input wire [3:0] program_strobe_n_mode_select, // Mode select straps
	input wire external_access_n, // High means programming voltage present
	input wire command_latch_strobe_n, // Latch strobe from programmer
	input wire program_strobe_n, // Program/dump strobe
	input wire address_step_n, // Auto-increment request
	input wire serial_rx, // Serial receive line
	input wire [15:0] programming_bus_in, // Bus level as seen on pins
	output reg [15:0] programming_bus_out, // Bus output value
	output reg [15:0] programming_bus_oe, // Bus drive enables
	output reg [1:0] upper_addr_out, // Upper address lines in auto/dump
	output reg location_verify_out, // Per-location verify
	output reg serial_tx, // Serial transmit line
	output reg cumulative_verify_out, // Cumulative verify
	output reg operation_active_n, // Auto/dump activity
	output reg program_strobe_n_entered, // Programming mode active
	output reg [3:0] active_mode // Latched mode
);

localparam [4:0] ST_IDLE = 5'h01, ST_CMD = 5'h02, ST_PROGRAM_STROBE_N = 5'h04, ST_DUMP = 5'h08,
	ST_RUN = 5'h10;

// ----------------------------------------
// Pin synchronisers
// ----------------------------------------
reg [2:0] ale_s, prg_s, inc_s, rx_s, ea_s;
reg [15:0] bus_s1, bus_s2, bus_s3;
reg [3:0] mode_s1, mode_s2, mode_s3;
always @(posedge core_clk) begin
	ale_s <= {ale_s[1:0], command_latch_strobe_n};
	prg_s <= {prg_s[1:0], program_strobe_n};
	inc_s <= {inc_s[1:0], address_step_n};
	rx_s <= {rx_s[1:0], serial_rx};
	ea_s <= {ea_s[1:0], external_access_n};
	bus_s1 <= programming_bus_in;
	bus_s2 <= bus_s1;
	bus_s3 <= bus_s2;
	mode_s1 <= program_strobe_n_mode_select;
	mode_s2 <= mode_s1;
	mode_s3 <= mode_s2;
end

// Filtered level: changes once stages two and three agree
reg ale_q, prg_q, inc_q, rx_q;
always @(posedge core_clk) begin
	if (reset) begin
		ale_q <= 1'b1;
		prg_q <= 1'b1;
		inc_q <= 1'b1;
		rx_q <= 1'b1;
	end else begin
		if (ale_s[1] == ale_s[2])
			ale_q <= ale_s[2];
		if (prg_s[1] == prg_s[2])
			prg_q <= prg_s[2];
		if (inc_s[1] == inc_s[2])
			inc_q <= inc_s[2];
		if (rx_s[1] == rx_s[2])
			rx_q <= rx_s[2];
	end
end
wire ale_fall = ale_q & ~ale_s[2] & (ale_s[1] == ale_s[2]);
wire prg_fall = prg_q & ~prg_s[2] & (prg_s[1] == prg_s[2]);
wire prg_rise = ~prg_q & prg_s[2] & (prg_s[1] == prg_s[2]);

// ----------------------------------------
// Mode capture at reset release
// ----------------------------------------
// Straps are taken on the first clock after release, from synchroniser stages that still hold levels sampled under reset
reg rst_d_q, cap_done_q;
always @(posedge core_clk) begin
	rst_d_q <= reset;
	if (reset) begin
		cap_done_q <= 1'b0;
		program_strobe_n_entered <= 1'b0;
		active_mode <= 4'h0;
	end else if (!cap_done_q) begin
		cap_done_q <= 1'b1;
		program_strobe_n_entered <= ea_s[2] & ea_s[1];
		active_mode <= mode_s3;
	end
end
wire mode_ok = program_strobe_n_entered & cap_done_q & ~rst_d_q;
wire in_slave = mode_ok & (active_mode == `OPM_MODE_SLAVE);
wire in_dump = mode_ok & (active_mode == `OPM_MODE_DUMP);
wire in_auto = mode_ok & (active_mode == `OPM_MODE_AUTO);
wire in_serial = mode_ok & (active_mode == `OPM_MODE_SERIAL);

// ----------------------------------------
// Array model and sequencer
// ----------------------------------------
// Small flip-flop array stands in for the cells; address wraps on its size
reg [15:0] mem_q [0:`OPM_MEM_DEPTH-1];
reg [4:0] state_q;
reg [14:0] addr_q;
reg cmd_program_strobe_n_q;
reg [15:0] data_q;
reg [15:0] cnt_q;
reg [3:0] tx_bit_q;
integer i;

function [3:0] idx;
	input [14:0] a;
	idx = a[`OPM_MEM_AW-1:0];
endfunction

always @(posedge core_clk) begin
	if (reset) begin
		state_q <= ST_IDLE;
		addr_q <= 15'h0000;
		cmd_program_strobe_n_q <= 1'b0;
		data_q <= 16'h0000;
		cnt_q <= 16'h0000;
		tx_bit_q <= 4'h0;
		programming_bus_out <= 16'h0000;
		programming_bus_oe <= 16'h0000;
		upper_addr_out <= 2'h0;
		location_verify_out <= 1'b1;
		cumulative_verify_out <= 1'b1;
		operation_active_n <= 1'b1;
		serial_tx <= 1'b1;
		for (i = 0; i < `OPM_MEM_DEPTH; i = i + 1)
			mem_q[i] <= `OPM_MEM_RESET;
	end else begin
		case (state_q)
		ST_IDLE: begin
			programming_bus_oe <= 16'h0000;
			if (in_slave && ale_fall) begin
				cmd_program_strobe_n_q <= bus_s3[`OPM_CMD_BIT];
				addr_q <= bus_s3[15:1];
				state_q <= ST_CMD;
			end else if ((in_auto || in_dump) && cnt_q == 16'h0000) begin
				operation_active_n <= 1'b0;
				state_q <= ST_RUN;
			end else if (in_serial) begin
				serial_tx <= mem_q[idx(addr_q)][tx_bit_q];
				tx_bit_q <= tx_bit_q + 4'h1;
				if (!rx_q)
					addr_q <= 15'h0000;
			end
		end
		ST_CMD: begin
			if (prg_fall) begin
				if (cmd_program_strobe_n_q) begin
					data_q <= bus_s3;
					state_q <= ST_PROGRAM_STROBE_N;
				end else begin
					programming_bus_out <= mem_q[idx(addr_q)];
					programming_bus_oe <= ~mem_q[idx(addr_q)];
					state_q <= ST_DUMP;
				end
			end
		end
		ST_PROGRAM_STROBE_N: begin
			// One-time cells only clear bits; pulse repeats while strobe is low
			mem_q[idx(addr_q)] <= mem_q[idx(addr_q)] & data_q;
			location_verify_out <= ((mem_q[idx(addr_q)] & data_q) == data_q);
			if ((mem_q[idx(addr_q)] & data_q) != data_q)
				cumulative_verify_out <= 1'b0;
			if (prg_rise) begin
				if (!inc_q) begin
					addr_q <= addr_q + 15'h0001;
					state_q <= ST_CMD;
				end else
					state_q <= ST_IDLE;
			end
		end
		ST_DUMP: begin
			if (prg_rise) begin
				programming_bus_oe <= 16'h0000;
				if (!inc_q) begin
					addr_q <= addr_q + 15'h0001;
					state_q <= ST_CMD;
				end else
					state_q <= ST_IDLE;
			end
		end
		ST_RUN: begin
			// Plain push-pull system bus: address out, data read back in auto mode only
			programming_bus_oe <= 16'h3fff;
			programming_bus_out <= {2'b00, cnt_q[13:0]};
			upper_addr_out <= cnt_q[15:14];
			if (in_auto) begin
				mem_q[idx(cnt_q[14:0])] <= mem_q[idx(cnt_q[14:0])] & bus_s3;
				location_verify_out <= ((mem_q[idx(cnt_q[14:0])] & bus_s3) == bus_s3);
			end else
				mem_q[idx(cnt_q[14:0])] <= mem_q[idx(cnt_q[14:0])];
			cnt_q <= cnt_q + 16'h0001;
			if (cnt_q == `OPM_AUTO_WORDS - 16'h0001) begin
				operation_active_n <= 1'b1;
				programming_bus_oe <= 16'h0000;
				state_q <= ST_IDLE;
			end
		end
		default: state_q <= ST_IDLE;
		endcase
	end
end
// Port 2 roles are fixed by the captured mode and do not move until reset

endmodule // opm_port
`default_nettype wire

// ==== tb/opm_port_asserts.sv ====
// Checker for the programming port outputs
`timescale 1ns/1ps
`default_nettype none
module opm_port_asserts (
	input wire logic core_clk, // Clock
	input wire logic reset, // Reset
	input wire logic [15:0] programming_bus_out, // Bus
	input wire logic [15:0] programming_bus_oe, // Enables
	input wire logic location_verify_out, // Verify
	input wire logic cumulative_verify_out, // Sum
	input wire logic operation_active_n, // Busy
	input wire logic program_strobe_n_entered, // Entered
	input wire logic [3:0] active_mode // Mode
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	wire slave = program_strobe_n_entered && active_mode == 4'h5;
	a_oe_needs_entry: assert property (|programming_bus_oe |-> program_strobe_n_entered)
		else $error("bus driven outside entry");
	a_open_drain: assert property (slave |-> !(|(programming_bus_oe & programming_bus_out)))
		else $error("bus driven high");
	a_mode_kept: assert property (program_strobe_n_entered |=> program_strobe_n_entered && $stable(active_mode))
		else $error("mode changed");
	a_cum_sticky: assert property (!cumulative_verify_out |=> !cumulative_verify_out)
		else $error("sum recovered");
	a_cum_follows: assert property (slave && $fell(location_verify_out) |-> ##[0:2] !cumulative_verify_out)
		else $error("sum missed fail");
	a_fail_in_mode: assert property ($fell(location_verify_out) |-> program_strobe_n_entered)
		else $error("verify fell idle");
	a_busy_ends: assert property ($fell(operation_active_n) |-> ##[1:60] operation_active_n)
		else $error("busy too long");
	a_slave_idle: assert property (slave |-> operation_active_n)
		else $error("busy in slave");
endmodule // opm_port_asserts
bind opm_port opm_port_asserts chk_i (.*);
`default_nettype wire

// ==== tb/opm_program_strobe_n_model.sv ====
// Programmer model: strobes and pulled-up open-drain bus
`timescale 1ns/1ps
`default_nettype none
module opm_program_strobe_n_model (
	input wire logic core_clk, // Clock
	input wire logic [15:0] programming_bus_out, // Bus
	input wire logic [15:0] programming_bus_oe, // Enables
	output wire logic [15:0] programming_bus_in, // Pins
	output logic command_latch_strobe_n = 1'b1, // Latch
	output logic program_strobe_n = 1'b1, // Program
	output logic address_step_n = 1'b1 // Step
);
	logic [15:0] d_q = 16'hffff;
	assign programming_bus_in = d_q & ~(programming_bus_oe & ~programming_bus_out);
	task automatic xfer(input logic [15:0] cmd, dat, input int n, output logic [15:0] rd);
		d_q <= cmd;
		@(posedge core_clk) command_latch_strobe_n <= 1'b0;
		repeat (6) @(posedge core_clk);
		command_latch_strobe_n <= 1'b1;
		d_q <= cmd[0] ? dat : 16'hffff;
		for (int i = 1; i <= n; i++) begin
			address_step_n <= i == n;
			program_strobe_n <= 1'b0;
			repeat (8) @(posedge core_clk);
			rd = programming_bus_in;
			program_strobe_n <= 1'b1;
			repeat (8) @(posedge core_clk);
		end
	endtask
endmodule // opm_program_strobe_n_model
`default_nettype wire

// ==== tb/tb_top.sv ====
// Testbench: mode entry, slave program and dump, activity
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic core_clk = 0, reset = 1, external_access_n = 0, serial_rx = 1;
	logic [3:0] program_strobe_n_mode_select = 4'h5, active_mode;
	logic [15:0] programming_bus_in, programming_bus_out, programming_bus_oe;
	logic [15:0] rd, d, s = 16'h0023;
	logic command_latch_strobe_n, program_strobe_n, address_step_n, serial_tx;
	logic location_verify_out, cumulative_verify_out, operation_active_n, program_strobe_n_entered;
	logic [1:0] upper_addr_out;
	logic [3:0] ml [4] = '{4'h0, 4'h6, 4'hc, 4'h3};
	logic [15:0] img [16];
	bit ok, cum;
	int errors = 0, comparisons = 0, cyc = 0;
	always #20 core_clk = ~core_clk;
	opm_port dut (.*);
	opm_program_strobe_n_model pm (.*);
	function automatic logic [15:0] lfsr(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction
	// Address 4 stands on the system bus eight edges after release
	function automatic logic [33:0] run_exp(input logic [3:0] m);
		return (m == 4'h6 || m == 4'hc) ? {2'b00, 16'h3fff, 16'h0004} : 34'h0;
	endfunction
	// Shadow of the cells: programming can only clear bits
	task automatic burn(input logic [3:0] a, input logic [15:0] v);
		ok = (img[a] & v) == v;
		cum &= ok;
		img[a] &= v;
	endtask
	task automatic chk(input logic [33:0] got, exp);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t: %h not %h", $time, got, exp);
		end
	endtask
	task automatic final_report;
		$display("errors %0d comparisons %0d", errors, comparisons);
		if (errors == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic boot(input logic [3:0] m, input logic v);
		reset <= 1'b1;
		program_strobe_n_mode_select <= m;
		external_access_n <= v;
		foreach (img[j]) img[j] = 16'hffff;
		cum = 1'b1;
		repeat (10) @(posedge core_clk);
		reset <= 1'b0;
		repeat (8) @(posedge core_clk);
	endtask
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 5000) begin
			errors++;
			$display("unexpected at %0t: timeout", $time);
			final_report;
		end
	end
	initial begin
		boot(4'h5, 1'b0);
		external_access_n <= 1'b1;
		repeat (8) @(posedge core_clk);
		chk(program_strobe_n_entered, 1'b0);
		boot(4'h5, 1'b1);
		chk({program_strobe_n_entered, active_mode}, 5'h15);
		s = lfsr(s);
		d = lfsr(s);
		pm.xfer({s[15:1], 1'b1}, d, 2, rd);
		chk(location_verify_out, 1'b1);
		pm.xfer({s[15:1] + 15'h1, 1'b0}, 0, 1, rd);
		chk(rd, d);
		pm.xfer({s[15:1], 1'b1}, ~d, 1, rd);
		chk({location_verify_out, cumulative_verify_out}, 2'b00);
		pm.xfer({s[15:1], 1'b0}, 0, 1, rd);
		chk(rd, 16'h0000);
		// Fresh array so the shadow image starts erased
		boot(4'h5, 1'b1);
		repeat (4) begin
			s = lfsr(d);
			d = lfsr(s);
			burn(s[4:1], d);
			pm.xfer({s[15:1], 1'b1}, d, 1, rd);
			chk({location_verify_out, cumulative_verify_out}, {ok, cum});
			pm.xfer({s[15:1], 1'b0}, 16'h0000, 1, rd);
			chk(rd, img[s[4:1]]);
		end
		foreach (ml[i]) begin
			boot(ml[i], 1'b1);
			chk({program_strobe_n_entered, active_mode}, {1'b1, ml[i]});
			chk(operation_active_n, run_exp(ml[i]) == 34'h0);
			chk({upper_addr_out, programming_bus_oe, programming_bus_out}, run_exp(ml[i]));
			repeat (40) @(posedge core_clk);
			chk({operation_active_n, serial_tx, location_verify_out}, 3'b111);
			chk(programming_bus_oe, 16'h0000);
		end
		reset <= 1'b1;
		repeat (2) @(posedge core_clk);
		chk({program_strobe_n_entered, programming_bus_oe, operation_active_n}, {1'b0, 16'h0000, 1'b1});
		final_report;
	end
endmodule // tb_top
`default_nettype wire
